//--- design/mdma_pkg.sv
// Shared constants for the multichannel DMA controller
package mdma_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int TRIG_N = 82;
    localparam int TRIG_W = 7;
    localparam int CH_N = 4;
    // Data space regions
    localparam logic [15:0] SFR_LAST = 16'h0FFF;
    localparam logic [15:0] RAM_FIRST = 16'h1000;
    localparam logic [15:0] RAM_LAST = 16'h4FFF;
    // Register map, word offsets; channel block at CH_BASE + 8*ch
    localparam logic [7:0] OFF_LIM_LO = 8'h00;
    localparam logic [7:0] OFF_LIM_HI = 8'h01;
    localparam logic [7:0] OFF_STAT = 8'h02;
    localparam logic [7:0] OFF_MASK = 8'h03;
    localparam logic [7:0] CH_BASE = 8'h10;
    localparam logic [2:0] CH_CTRL = 3'h0;
    localparam logic [2:0] CH_SRC = 3'h1;
    localparam logic [2:0] CH_DST = 3'h2;
    localparam logic [2:0] CH_CNT = 3'h3;
    localparam logic [2:0] CH_TRIG = 3'h4;
    localparam logic [2:0] CH_LIVE = 3'h5;
    // Control field positions
    localparam int B_EN = 0;
    localparam int B_SIZE = 1;
    localparam int B_MODE = 2;
    localparam int B_SAM = 4;
    localparam int B_DAM = 6;
    localparam int B_RELOAD = 8;
    localparam int B_SPIA = 9;
    localparam int B_DPIA = 10;
    // Reset values: word size by default
    localparam logic [15:0] CTRL_RST = 16'h0002;
    localparam logic [15:0] LIM_LO_RST = 16'h1000;
    localparam logic [15:0] LIM_HI_RST = 16'h4FFF;
    typedef enum logic [1:0] {MD_ONE, MD_CONT, MD_REP_ONE, MD_REP_CONT} mdma_mode_t;
    typedef enum logic [1:0] {AM_FIX, AM_INC, AM_DEC, AM_RSV} mdma_am_t;
endpackage

//--- design/mdma_arb.sv
// Fixed priority arbiter, lowest index wins
module mdma_arb #(
    parameter int N = 4
) (
    input wire logic [N-1:0] req,
    output logic [N-1:0] gnt,
    output logic any
);
    // Scan from the top so the lowest request is left standing
    always_comb begin
        gnt = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i]) begin
                gnt = '0;
                gnt[i] = 1'b1;
            end
        end
        any = |req;
    end
endmodule

//--- design/mdma_ctrl.sv
// Multichannel DMA controller core with register port and bus master
// How it works
// - Addresses span register and RAM regions
// - RAM accesses outside limits abort, interrupt
// - Per-channel byte/word size, word after reset
// - Byte mode: address LSB picks lane
// - Any of 82 triggers selectable, reversed
// - Trigger independent; completions chain channels
// - One-shot: one transfer per trigger
// - Continuous: one trigger runs full count
// - Repeated one-shot: per trigger until disabled
// - Repeated continuous: series per trigger, repeats
// - Optional reload of addresses and count
// - Fixed or block source and destination
// - Block addresses step up or down
// - Peripheral indirect: base plus peripheral offset
// - Priority arbitration among requesting channels
// - Channels configured and run independently
module mdma_ctrl #(
    parameter int N = mdma_pkg::CH_N
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic [mdma_pkg::TRIG_N-1:0] irq_src,
    input wire logic [N*8-1:0] pia_offset,
    output logic [mdma_pkg::ADDR_W-1:0] mem_addr,
    output logic mem_rd,
    output logic mem_wr,
    output logic [1:0] mem_be,
    output logic [mdma_pkg::DATA_W-1:0] mem_wdata,
    input wire logic [mdma_pkg::DATA_W-1:0] mem_rdata,
    output logic irq
);
    import mdma_pkg::*;
    typedef enum {ST_IDLE, ST_READ, ST_WRITE} mdma_st_t;

    logic [15:0] ctrl_reg [N];
    logic [15:0] src_reg [N];
    logic [15:0] dst_reg [N];
    logic [15:0] cnt_reg [N];
    logic [15:0] src0_reg [N];
    logic [15:0] dst0_reg [N];
    logic [15:0] cnt0_reg [N];
    logic [TRIG_W-1:0] tsel_reg [N];
    logic [N-1:0] run_reg;
    logic [N-1:0] done_pulse;
    logic [15:0] lim_lo_reg;
    logic [15:0] lim_hi_reg;
    logic [2*N-1:0] stat_reg;
    logic [2*N-1:0] mask_reg;
    logic [2*N-1:0] ev_set;
    logic [N-1:0] req;
    logic [N-1:0] gnt;
    logic any_req;
    mdma_st_t st_reg;
    logic [$clog2(N)-1:0] cur_reg;
    logic [15:0] data_reg;
    logic [15:0] ea_src;
    logic [15:0] ea_dst;
    logic limit_err;
    logic [$clog2(N)-1:0] gnt_idx;
    logic [7:0] rd_byte;
    logic [15:0] rd_value;
    logic [2*N-1:0] stat_clr;

    // Step an address per addressing mode
    function automatic logic [15:0] step_addr(input logic [15:0] a, input logic [1:0] am, input logic bsz);
        logic [15:0] d;
        d = bsz ? 16'h0001 : 16'h0002;
        case (mdma_am_t'(am))
            AM_INC: step_addr = a + d;
            AM_DEC: step_addr = a - d;
            default: step_addr = a;
        endcase
    endfunction

    // Check RAM access against protection limits
    function automatic logic out_of_lim(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
        out_of_lim = (a >= RAM_FIRST) && ((a < lo) || (a > hi) || (a > RAM_LAST));
    endfunction

    // Reversed trigger numbering: selection 0 is the last source
    function automatic logic trig_hit(input logic [TRIG_N-1:0] s, input logic [TRIG_W-1:0] sel);
        trig_hit = (sel < TRIG_W'(TRIG_N)) ? s[TRIG_N - 1 - int'(sel)] : 1'b0;
    endfunction

    // Upper address bits of a channel's register block
    function automatic logic [4:0] ch_slot(input int ch);
        ch_slot = 5'((int'(CH_BASE) >> 3) + ch);
    endfunction

    mdma_arb #(.N(N)) u_arb (
        .req(req),
        .gnt(gnt),
        .any(any_req)
    );

    // Grant is one-hot and no lower channel is left waiting
    a_grant_lowest: assert property (@(posedge clk) disable iff (!resetn)
        any_req |-> $onehot(gnt) && ((req & (gnt - N'(1))) == '0))
        else $error("grant not given to the lowest requesting channel");

    // Grant index and effective addresses of the current channel
    always_comb begin
        gnt_idx = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (gnt[i]) begin
                gnt_idx = i[$clog2(N)-1:0];
            end
        end
        ea_src = src_reg[cur_reg];
        ea_dst = dst_reg[cur_reg];
        if (ctrl_reg[cur_reg][B_SPIA]) begin
            ea_src = src_reg[cur_reg] + {8'h00, pia_offset[cur_reg*8 +: 8]};
        end
        if (ctrl_reg[cur_reg][B_DPIA]) begin
            ea_dst = dst_reg[cur_reg] + {8'h00, pia_offset[cur_reg*8 +: 8]};
        end
        limit_err = out_of_lim(ea_src, lim_lo_reg, lim_hi_reg) || out_of_lim(ea_dst, lim_lo_reg, lim_hi_reg);
    end

    // Requests: a running channel asks for the bus between beats
    always_comb begin
        for (int i = 0; i < N; i++) begin
            req[i] = run_reg[i] && ctrl_reg[i][B_EN] && (st_reg == ST_IDLE);
        end
    end

    // Transfer engine: read source then write destination
    always_ff @(posedge clk) begin
        if (!resetn) begin
            st_reg <= ST_IDLE;
            cur_reg <= '0;
            data_reg <= 16'h0000;
        end else begin
            case (st_reg)
                ST_IDLE: begin
                    if (any_req) begin
                        cur_reg <= gnt_idx;
                        st_reg <= ST_READ;
                    end
                end
                ST_READ: begin
                    if (limit_err) begin
                        st_reg <= ST_IDLE;
                    end else begin
                        data_reg <= ctrl_reg[cur_reg][B_SIZE] ? mem_rdata : {8'h00, rd_byte};
                        st_reg <= ST_WRITE;
                    end
                end
                ST_WRITE: st_reg <= ST_IDLE;
                default: st_reg <= ST_IDLE;
            endcase
        end
    end

    // Beat sequences: a clean read, a single write beat, a limit hit
    sequence s_read_ok;
        st_reg == ST_READ && !limit_err;
    endsequence
    sequence s_write_beat;
        mem_wr && !mem_rd ##1 !mem_wr;
    endsequence
    sequence s_limit_hit;
        st_reg == ST_READ && limit_err;
    endsequence
    a_read_write_pair: assert property (@(posedge clk) disable iff (!resetn) s_read_ok |=> s_write_beat)
        else $error("read beat not followed by one write beat");
    a_limit_no_write: assert property (@(posedge clk) disable iff (!resetn)
        s_limit_hit |-> !mem_rd ##1 !mem_wr)
        else $error("limit violation still reached the bus");
    a_limit_flag: assert property (@(posedge clk) disable iff (!resetn)
        s_limit_hit |=> (|ev_set[2*N-1:N]) && !run_reg[$past(cur_reg)])
        else $error("limit violation did not stop the channel");

    // Bus outputs; register space and RAM inside the limits are reachable in both directions
    always_comb begin
        mem_rd = (st_reg == ST_READ) && !limit_err;
        mem_wr = (st_reg == ST_WRITE);
        mem_addr = (st_reg == ST_WRITE) ? ea_dst : ea_src;
        if (ctrl_reg[cur_reg][B_SIZE]) begin
            mem_be = 2'b11;
        end else begin
            mem_be = mem_addr[0] ? 2'b10 : 2'b01;
        end
        mem_wdata = data_reg;
        if (!ctrl_reg[cur_reg][B_SIZE]) begin
            mem_wdata = ea_dst[0] ? {data_reg[7:0], 8'h00} : {8'h00, data_reg[7:0]};
        end
    end

    // Byte read lane picked by the source LSB
    assign rd_byte = ea_src[0] ? mem_rdata[15:8] : mem_rdata[7:0];

    // A byte beat enables exactly the lane its address selects
    a_byte_lane: assert property (@(posedge clk) disable iff (!resetn)
        (mem_rd || mem_wr) && !ctrl_reg[cur_reg][B_SIZE] |-> $onehot(mem_be) && (mem_be[1] == mem_addr[0]))
        else $error("byte beat enabled the wrong lane");

    // Per-channel state: triggers, counting, addressing, reload
    always_ff @(posedge clk) begin
        if (!resetn) begin
            run_reg <= '0;
            done_pulse <= '0;
            ev_set <= '0;
            for (int i = 0; i < N; i++) begin
                ctrl_reg[i] <= CTRL_RST;
                src_reg[i] <= 16'h0000;
                dst_reg[i] <= 16'h0000;
                cnt_reg[i] <= 16'h0000;
                src0_reg[i] <= 16'h0000;
                dst0_reg[i] <= 16'h0000;
                cnt0_reg[i] <= 16'h0000;
                tsel_reg[i] <= '0;
            end
        end else begin
            done_pulse <= '0;
            ev_set <= '0;
            for (int i = 0; i < N; i++) begin
                // Trigger hit: external source, or the previous channel's completion
                if (ctrl_reg[i][B_EN] && !run_reg[i] &&
                    (trig_hit(irq_src, tsel_reg[i]) || (i > 0 && tsel_reg[i] == TRIG_W'(TRIG_N) && done_pulse[(i+N-1)%N])))
                begin
                    run_reg[i] <= 1'b1;
                end
                if (!ctrl_reg[i][B_EN]) begin
                    run_reg[i] <= 1'b0;
                end
            end
            if (st_reg == ST_READ && limit_err) begin
                run_reg[cur_reg] <= 1'b0;
                ctrl_reg[cur_reg][B_EN] <= 1'b0;
                ev_set[N + int'(cur_reg)] <= 1'b1;
            end
            if (st_reg == ST_WRITE) begin
                src_reg[cur_reg] <= step_addr(src_reg[cur_reg], ctrl_reg[cur_reg][B_SAM +: 2],
                    !ctrl_reg[cur_reg][B_SIZE]);
                dst_reg[cur_reg] <= step_addr(dst_reg[cur_reg], ctrl_reg[cur_reg][B_DAM +: 2],
                    !ctrl_reg[cur_reg][B_SIZE]);
                cnt_reg[cur_reg] <= cnt_reg[cur_reg] - 16'h0001;
                case (mdma_mode_t'(ctrl_reg[cur_reg][B_MODE +: 2]))
                    MD_ONE, MD_REP_ONE: run_reg[cur_reg] <= 1'b0;
                    default: run_reg[cur_reg] <= (cnt_reg[cur_reg] > 16'h0001);
                endcase
                if (cnt_reg[cur_reg] <= 16'h0001) begin
                    done_pulse[cur_reg] <= 1'b1;
                    ev_set[cur_reg] <= 1'b1;
                    run_reg[cur_reg] <= 1'b0;
                    if (ctrl_reg[cur_reg][B_MODE +: 2] == 2'(MD_ONE) || ctrl_reg[cur_reg][B_MODE +: 2] == 2'(MD_CONT)) begin
                        ctrl_reg[cur_reg][B_EN] <= 1'b0;
                    end
                    if (ctrl_reg[cur_reg][B_RELOAD]) begin
                        src_reg[cur_reg] <= src0_reg[cur_reg];
                        dst_reg[cur_reg] <= dst0_reg[cur_reg];
                        cnt_reg[cur_reg] <= cnt0_reg[cur_reg];
                    end
                end
            end
            // Software writes to channel registers
            if (reg_wr && reg_addr >= CH_BASE) begin
                for (int i = 0; i < N; i++) begin
                    if (reg_addr[7:3] == ch_slot(i)) begin
                        case (reg_addr[2:0])
                            CH_CTRL: ctrl_reg[i] <= reg_wdata;
                            CH_SRC: begin src_reg[i] <= reg_wdata; src0_reg[i] <= reg_wdata; end
                            CH_DST: begin dst_reg[i] <= reg_wdata; dst0_reg[i] <= reg_wdata; end
                            CH_CNT: begin cnt_reg[i] <= reg_wdata; cnt0_reg[i] <= reg_wdata; end
                            CH_TRIG: tsel_reg[i] <= reg_wdata[TRIG_W-1:0];
                            default: ;
                        endcase
                    end
                end
            end
        end
    end

    // A one-shot beat always ends the channel's run
    a_one_shot_stop: assert property (@(posedge clk) disable iff (!resetn)
        (st_reg == ST_WRITE) && !ctrl_reg[cur_reg][B_MODE] |=> !run_reg[$past(cur_reg)])
        else $error("one-shot channel kept running after its beat");

    // The last counted beat raises the completion event
    a_count_done: assert property (@(posedge clk) disable iff (!resetn)
        (st_reg == ST_WRITE) && (cnt_reg[cur_reg] <= 16'h0001) |=> (|ev_set[N-1:0]))
        else $error("last beat raised no completion event");

    // Limit registers and interrupt mask, written by software
    always_ff @(posedge clk) begin
        if (!resetn) begin
            lim_lo_reg <= LIM_LO_RST;
            lim_hi_reg <= LIM_HI_RST;
            mask_reg <= '0;
        end else if (reg_wr) begin
            case (reg_addr)
                OFF_LIM_LO: lim_lo_reg <= reg_wdata;
                OFF_LIM_HI: lim_hi_reg <= reg_wdata;
                OFF_MASK: mask_reg <= reg_wdata[2*N-1:0];
                default: ;
            endcase
        end
    end

    // Sticky status, write-one clear: low half completions, high half limit errors
    assign stat_clr = (reg_wr && reg_addr == OFF_STAT) ? reg_wdata[2*N-1:0] : '0;
    always_ff @(posedge clk) begin
        if (!resetn) begin
            stat_reg <= '0;
        end else begin
            stat_reg <= (stat_reg & ~stat_clr) | ev_set;
        end
    end

    // An event lands in status even under a clear in the same cycle
    a_event_sticky: assert property (@(posedge clk) disable iff (!resetn)
        (|ev_set) |=> ((stat_reg & $past(ev_set)) == $past(ev_set)))
        else $error("status event lost under a clear");

    // Level interrupt from the unmasked status bits
    always_ff @(posedge clk) begin
        if (!resetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(stat_reg & mask_reg);
        end
    end

    // Read mux: shared registers, then channel blocks; the live count sits apart from the start count
    always_comb begin
        rd_value = 16'h0000;
        case (reg_addr)
            OFF_LIM_LO: rd_value = lim_lo_reg;
            OFF_LIM_HI: rd_value = lim_hi_reg;
            OFF_STAT: rd_value = 16'(stat_reg);
            OFF_MASK: rd_value = 16'(mask_reg);
            default: ;
        endcase
        for (int i = 0; i < N; i++) begin
            if (reg_addr[7:3] == ch_slot(i)) begin
                case (reg_addr[2:0])
                    CH_CTRL: rd_value = ctrl_reg[i];
                    CH_SRC: rd_value = src0_reg[i];
                    CH_DST: rd_value = dst0_reg[i];
                    CH_CNT: rd_value = cnt0_reg[i];
                    CH_TRIG: rd_value = 16'(tsel_reg[i]);
                    CH_LIVE: rd_value = cnt_reg[i];
                    default: ;
                endcase
            end
        end
    end

    // Read data stand for the one cycle after the strobe
    always_ff @(posedge clk) begin
        if (!resetn) begin
            reg_rdata <= 16'h0000;
        end else begin
            reg_rdata <= reg_rd ? rd_value : 16'h0000;
        end
    end
endmodule

//--- verification/mdma_mem_model.sv
// Data space model: one word array behind the controller's bus master
module mdma_mem_model (
    input wire logic clk,
    input wire logic [15:0] addr,
    input wire logic rd,
    input wire logic wr,
    input wire logic [1:0] be,
    input wire logic [15:0] wdata,
    output logic [15:0] rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] mem [0:32767];
    // Byte lanes by enable; register and RAM regions alike
    always @(posedge clk) begin
        if (wr && be[0]) mem[addr[15:1]][7:0] <= wdata[7:0];
        if (wr && be[1]) mem[addr[15:1]][15:8] <= wdata[15:8];
    end
    // Read data answer in the strobe's own cycle; an idle bus shows the inverse word
    assign rdata = rd ? mem[addr[15:1]] : ~mem[addr[15:1]];
endmodule

//--- verification/multichannel_dma_controller_tb.sv
// Self-checking bench for the multichannel DMA controller
module multichannel_dma_controller_tb;
    import mdma_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {logic [15:0] a; logic [1:0] be; logic [15:0] d;} mdma_exp_t;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic rd_d = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic [TRIG_N-1:0] irq_src = '0;
    logic [CH_N*8-1:0] pia_offset = '0;
    logic [15:0] reg_rdata, mem_addr, mem_wdata, mem_rdata;
    logic [1:0] mem_be;
    logic mem_rd, mem_wr, irq;
    mdma_exp_t wq[$];
    logic [15:0] rq[$];
    int num_errors = 0;
    int checked = 0;
    int seed = 22;
    always #5 clk = ~clk;
    mdma_ctrl #(.N(CH_N)) dut_u (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_src(irq_src), .pia_offset(pia_offset),
        .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_be(mem_be), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .irq(irq));
    mdma_mem_model mem_u (.clk(clk), .addr(mem_addr), .rd(mem_rd), .wr(mem_wr), .be(mem_be),
        .wdata(mem_wdata), .rdata(mem_rdata));
    task automatic chk(input string what, input logic [33:0] exp, input logic [33:0] seen);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Watcher: each read datum or bus write takes the oldest note
    always @(posedge clk) begin
        mdma_exp_t e;
        rd_d <= reg_rd;
        if (rd_d) chk("reg_rdata", rq.size() ? {18'h0, rq.pop_front()} : 'x, {18'h0, reg_rdata});
        if (mem_wr) begin
            e = wq.size() ? wq.pop_front() : 'x;
            chk("mem_write", {e.a, e.be, e.d & {{8{e.be[1]}}, {8{e.be[0]}}}},
                {mem_addr, mem_be, mem_wdata & {{8{e.be[1]}}, {8{e.be[0]}}}});
        end
    end
    task automatic rw(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rr(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk);
        rq.push_back(e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask
    function automatic logic [15:0] ctl(input logic [1:0] md, input logic [1:0] sam, input logic [1:0] dam,
                                        input logic wd, input logic rl);
        ctl = 16'h0001 | (16'(wd) << B_SIZE) | (16'(md) << B_MODE) | (16'(sam) << B_SAM) | (16'(dam) << B_DAM)
            | (16'(rl) << B_RELOAD);
    endfunction
    // Addresses and count first, control with enable last
    task automatic cfg(input int ch, input logic [15:0] c, input logic [15:0] s, input logic [15:0] d,
                       input logic [15:0] n, input int t);
        logic [7:0] b;
        b = CH_BASE + 8'(ch * 8);
        rw({b[7:3], CH_SRC}, s);
        rw({b[7:3], CH_DST}, d);
        rw({b[7:3], CH_CNT}, n);
        rw({b[7:3], CH_TRIG}, 16'(t));
        rw({b[7:3], CH_CTRL}, c);
    endtask
    task automatic trig(input int t);
        @(posedge clk);
        irq_src[TRIG_N - 1 - t] <= 1'b1;
        @(posedge clk);
        irq_src[TRIG_N - 1 - t] <= 1'b0;
    endtask
    task automatic settle;
        int n;
        n = 0;
        while (wq.size() != 0 && n < 400) begin
            @(posedge clk);
            n++;
        end
        if (wq.size() != 0) begin
            num_errors++;
            $display("CHECK FAILED pending_writes expected 0 seen %0d", wq.size());
            test_done;
        end
        repeat (30) @(posedge clk);
    endtask
    initial begin
        logic [15:0] v;
        int t;
        pia_offset <= 32'($random(seed));
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        for (int c = 0; c < CH_N; c++) rr(CH_BASE + 8'(c * 8), CTRL_RST);
        rr(OFF_LIM_LO, LIM_LO_RST);
        rr(OFF_LIM_HI, LIM_HI_RST);
        rw(OFF_MASK, 16'hFFFF);
        $display("test reset_values done");
        // Continuous word run from RAM into register space
        t = {$random(seed)} % TRIG_N;
        for (int i = 0; i < 4; i++) begin
            v = 16'($random(seed));
            mem_u.mem[16'h0800 + i] = v;
            wq.push_back({16'h0800 + 16'(2 * i), 2'b11, v});
        end
        cfg(1, ctl(MD_CONT, AM_INC, AM_INC, 1'b1, 1'b0), 16'h1000, 16'h0800, 16'h0004, t);
        trig(t);
        settle;
        rr(OFF_STAT, 16'h0002);
        chk("irq", 34'h1, {33'h0, irq});
        rw(OFF_STAT, 16'h0002);
        repeat (2) @(posedge clk);
        chk("irq", 34'h0, {33'h0, irq});
        rr(CH_BASE + 8'h08 + 8'(CH_LIVE), 16'h0000);
        $display("test continuous done");
        // One-shot bytes: odd fixed source, decrementing destination
        v = 16'($random(seed));
        mem_u.mem[16'h0880] = v;
        t = {$random(seed)} % TRIG_N;
        cfg(0, ctl(MD_ONE, AM_FIX, AM_DEC, 1'b0, 1'b0), 16'h1101, 16'h2003, 16'h0002, t);
        wq.push_back({16'h2003, 2'b10, v[15:8], v[15:8]});
        trig(t);
        settle;
        wq.push_back({16'h2002, 2'b01, v[15:8], v[15:8]});
        trig(t);
        settle;
        $display("test one_shot_byte done");
        // Two channels on one trigger: lower number goes first
        mem_u.mem[16'h0900] = 16'h1234;
        mem_u.mem[16'h0980] = 16'hABCD;
        t = {$random(seed)} % TRIG_N;
        cfg(3, ctl(MD_ONE, AM_FIX, AM_FIX, 1'b1, 1'b0), 16'h1300, 16'h0102, 16'h0001, t);
        cfg(2, ctl(MD_ONE, AM_FIX, AM_FIX, 1'b1, 1'b0), 16'h1200, 16'h0100, 16'h0001, t);
        wq.push_back({16'h0100, 2'b11, 16'h1234});
        wq.push_back({16'h0102, 2'b11, 16'hABCD});
        trig(t);
        settle;
        rw(CH_BASE + 8'h10, 16'h0000);
        trig(t);
        settle;
        $display("test priority done");
        // Peripheral offset added to a fixed destination base
        cfg(2, ctl(MD_ONE, AM_FIX, AM_FIX, 1'b1, 1'b0) | (16'h0001 << B_DPIA), 16'h1200, 16'h0200, 16'h0001, t);
        wq.push_back({16'h0200 + {8'h00, pia_offset[23:16]}, 2'b11, 16'h1234});
        trig(t);
        settle;
        $display("test indirect done");
        // Repeated series on channel 1; its completion chains channel 2
        cfg(2, ctl(MD_ONE, AM_FIX, AM_FIX, 1'b1, 1'b0), 16'h1300, 16'h0104, 16'h0001, TRIG_N);
        cfg(1, ctl(MD_REP_CONT, AM_INC, AM_INC, 1'b1, 1'b1), 16'h1000, 16'h0600, 16'h0002, t);
        for (int r = 0; r < 2; r++) begin
            for (int i = 0; i < 2; i++) begin
                wq.push_back({16'h0600 + 16'(2 * i), 2'b11, mem_u.mem[16'h0800 + i]});
            end
            if (r == 0) wq.push_back({16'h0104, 2'b11, 16'hABCD});
            trig(t);
            settle;
        end
        rw(CH_BASE + 8'h08, 16'h0000);
        $display("test repeat_series done");
        // Repeated one-shot with reload: same place every trigger
        cfg(3, ctl(MD_REP_ONE, AM_INC, AM_INC, 1'b1, 1'b1), 16'h1300, 16'h1400, 16'h0001, t);
        for (int i = 0; i < 3; i++) begin
            wq.push_back({16'h1400, 2'b11, 16'hABCD});
            trig(t);
            settle;
        end
        $display("test repeat_reload done");
        // Destination above the upper RAM limit ends without a write
        rw(OFF_STAT, 16'hFFFF);
        rw(CH_BASE + 8'h18, 16'h0000);
        repeat (2) @(posedge clk);
        chk("irq", 34'h0, {33'h0, irq});
        rw(OFF_LIM_HI, 16'h1FFF);
        cfg(0, ctl(MD_ONE, AM_FIX, AM_FIX, 1'b1, 1'b0), 16'h1000, 16'h3000, 16'h0001, t);
        trig(t);
        settle;
        chk("irq", 34'h1, {33'h0, irq});
        $display("test ram_limit done");
        test_done;
    end
endmodule
